// ===== pcs1_top.sv
// Performance counter 1 select control with APB register access
// Assumes event inputs are synchronous to clk_i, index 0 receive, 1 transmit
//
// Contract
// - Priority-0 select bit 19 makes counter 1 count priority-0 packets.
// - All four priority selects zero disables counter 1 entirely.
// - Bits 16, 17, 18 select priorities 3, 2, 1; read/write, reset zero.
// - Bit 23 chooses receive (0) or transmit (1) traffic; resets to 0.
// - Type 000 counts unicast requests only, no responses or maintenance.
// - Type 001 counts every unicast packet including maintenance packets.
// - Type 010 counts retry control symbols only.
// - Type 011 counts all control symbols except retry symbols.
// - Type 100 adds one per 32-bit word of accepted unicast packets.
// - Type 101 counts multicast packets only.
// - Type 110 counts multicast control symbols.
// - Type 111 adds one per 32-bit word of multicast packets.
// - Packet-based types count retried packets each time they appear.
`timescale 1ns/1ps
`include "pcs1_consts.svh"

module pcs1_top (
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [`PCS1_ADDR_W-1:0]       paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    input  wire logic [3:0]                    pstrb_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic [1:0]                    pkt_valid_i,
    input  wire logic [1:0][1:0]               pkt_prio_i,
    input  wire logic [1:0]                    pkt_unicast_i,
    input  wire logic [1:0]                    pkt_multicast_i,
    input  wire logic [1:0]                    pkt_request_i,
    input  wire logic [1:0][`PCS1_WORD_W-1:0]  pkt_words_i,
    input  wire logic [1:0]                    sym_valid_i,
    input  wire logic [1:0]                    sym_retry_i,
    input  wire logic [1:0]                    sym_multicast_i,
    output logic      [31:0]                   ctr1_count_o,
    output logic                               ctr1_enabled_o
);

    logic [31:0]             ctrl_ff;
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic                    wrap_seen_ff;
    logic                    enabled_ff;
    logic [31:0]             rd_val;
    logic [31:0]             wmask;
    logic                    addr_ok;
    logic                    access;
    logic                    done;
    logic                    wr_ctrl;
    logic                    wr_count;
    logic                    wr_status;
    logic [3:0]              ctr1_priority_selects;
    logic                    ctr1_direction_select;
    logic [2:0]              ctr1_event_type_select;
    logic [`PCS1_WORD_W-1:0] inc;
    logic [31:0]             count;
    logic                    wrap;

    // Control fields
    assign ctr1_priority_selects = {ctrl_ff[`PCS1_PRIO3_BIT],
                                    ctrl_ff[`PCS1_PRIO2_BIT],
                                    ctrl_ff[`PCS1_PRIO1_BIT],
                                    ctrl_ff[`PCS1_PRIO0_BIT]};
    assign ctr1_direction_select  = ctrl_ff[`PCS1_DIR_BIT];
    assign ctr1_event_type_select =
        ctrl_ff[`PCS1_TYPE_MSB:`PCS1_TYPE_LSB];

    // APB decode
    assign access = psel_i && penable_i;
    assign done   = access && pready_ff;
    assign wmask  = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}},
                     {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    always_comb begin
        addr_ok = 1'b1;
        rd_val  = 32'h0000_0000;
        case (paddr_i)
            `PCS1_OFF_CTRL:   rd_val = ctrl_ff & `PCS1_CTRL_WMASK;
            `PCS1_OFF_COUNT:  rd_val = count;
            `PCS1_OFF_STATUS: begin
                rd_val[`PCS1_STS_EN_BIT]   = enabled_ff;
                rd_val[`PCS1_STS_WRAP_BIT] = wrap_seen_ff;
            end
            default:          addr_ok = 1'b0;
        endcase
    end

    assign wr_ctrl   = done && pwrite_i && (paddr_i == `PCS1_OFF_CTRL);
    assign wr_count  = done && pwrite_i && (paddr_i == `PCS1_OFF_COUNT);
    assign wr_status = done && pwrite_i && (paddr_i == `PCS1_OFF_STATUS);

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !addr_ok;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (access && !pready_ff && !pwrite_i) begin
            prdata_ff <= rd_val;
        end else if (done) begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // Only the documented fields store; reserved bits stay zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_ff <= `PCS1_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= (ctrl_ff & ~(wmask & `PCS1_CTRL_WMASK))
                     | (pwdata_i & wmask & `PCS1_CTRL_WMASK);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enabled_ff <= 1'b0;
        end else begin
            enabled_ff <= |ctr1_priority_selects;
        end
    end

    // Sticky wrap flag; a new wrap beats a write-one clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wrap_seen_ff <= 1'b0;
        end else if (wrap) begin
            wrap_seen_ff <= 1'b1;
        end else if (wr_status && pstrb_i[0]
                     && pwdata_i[`PCS1_STS_WRAP_BIT]) begin
            wrap_seen_ff <= 1'b0;
        end
    end

    pcs1_event_qual u_qual (
        .clk_i           (clk_i),
        .rstn_i          (rstn_i),
        .prio_sel_i      (ctr1_priority_selects),
        .dir_i           (ctr1_direction_select),
        .type_i          (pcs1_pkg::pcs1_evtype_type'(
                              ctr1_event_type_select)),
        .pkt_valid_i     (pkt_valid_i),
        .pkt_prio_i      (pkt_prio_i),
        .pkt_unicast_i   (pkt_unicast_i),
        .pkt_multicast_i (pkt_multicast_i),
        .pkt_request_i   (pkt_request_i),
        .pkt_words_i     (pkt_words_i),
        .sym_valid_i     (sym_valid_i),
        .sym_retry_i     (sym_retry_i),
        .sym_multicast_i (sym_multicast_i),
        .inc_o           (inc)
    );

    pcs1_counter u_counter (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .clr_i   (wr_count),
        .inc_i   (inc),
        .count_o (count),
        .wrap_o  (wrap)
    );

    assign prdata_o       = prdata_ff;
    assign pready_o       = pready_ff;
    assign pslverr_o      = pslverr_ff;
    assign ctr1_count_o   = count;
    assign ctr1_enabled_o = enabled_ff;

    // Helper terms for the checks below
    logic                    dir;
    logic [2:0]              typ;
    logic                    en;
    logic                    pkt_hit;
    logic                    sym_hit;
    logic [`PCS1_WORD_W-1:0] words_sel;

    assign dir       = ctr1_direction_select;
    assign typ       = ctr1_event_type_select;
    assign en        = |ctr1_priority_selects;
    assign pkt_hit   = en && pkt_valid_i[dir]
                       && ctr1_priority_selects[pkt_prio_i[dir]];
    assign sym_hit   = en && sym_valid_i[dir];
    assign words_sel = pkt_words_i[dir];

    default clocking @(posedge clk_i);
    endclocking

    default disable iff (!rstn_i);

    chk_prio_zero_count:
    assert property (ctrl_ff[`PCS1_PRIO0_BIT] && !dir
                     && typ == `PCS1_EVT_UALL && pkt_valid_i[0]
                     && pkt_prio_i[0] == 2'h0 && pkt_unicast_i[0]
                     |=> inc == 7'h01)
    else $error("priority 0 unicast packet not counted");

    chk_disabled_idle:
    assert property (!en ##1 !wr_count
                     |-> inc == 7'h00 ##1 count == $past(count, 1))
    else $error("disabled counter accumulated");

    chk_prio_bit_mask:
    assert property (!ctrl_ff[`PCS1_PRIO3_BIT] && typ == `PCS1_EVT_UALL
                     && pkt_valid_i[dir] && pkt_prio_i[dir] == 2'h3
                     && !sym_valid_i[dir]
                     |=> inc == 7'h00)
    else $error("unselected priority 3 packet counted");

    chk_dir_select:
    assert property (dir && !pkt_valid_i[1] && !sym_valid_i[1]
                     |=> inc == 7'h00)
    else $error("receive traffic counted in transmit mode");

    chk_req_only:
    assert property (typ == `PCS1_EVT_UREQ
                     && !(pkt_valid_i[dir] && pkt_request_i[dir])
                     |=> inc == 7'h00)
    else $error("non-request packet counted as request");

    chk_all_unicast:
    assert property (typ == `PCS1_EVT_UALL && pkt_hit
                     && pkt_unicast_i[dir]
                     |=> inc == 7'h01)
    else $error("unicast packet not counted");

    chk_retry_sym:
    assert property (typ == `PCS1_EVT_RETRY && sym_hit
                     && sym_retry_i[dir]
                     |=> inc == 7'h01)
    else $error("retry symbol not counted");

    chk_other_sym:
    assert property (typ == `PCS1_EVT_CSYM
                     && !(sym_hit && !sym_retry_i[dir])
                     |=> inc == 7'h00)
    else $error("retry symbol counted as other symbol");

    chk_unicast_words:
    assert property (typ == `PCS1_EVT_UWORD && pkt_hit
                     && pkt_unicast_i[dir]
                     |=> inc == $past(words_sel))
    else $error("unicast word count wrong");

    chk_mcast_pkt:
    assert property (typ == `PCS1_EVT_MPKT
                     && !(pkt_hit && pkt_multicast_i[dir])
                     |=> inc == 7'h00)
    else $error("non-multicast packet counted");

    chk_mcast_sym:
    assert property (typ == `PCS1_EVT_MSYM && sym_hit
                     && sym_multicast_i[dir]
                     |=> inc == 7'h01)
    else $error("multicast symbol not counted");

    chk_mcast_words:
    assert property (typ == `PCS1_EVT_MWORD && pkt_hit
                     && pkt_multicast_i[dir]
                     |=> inc == $past(words_sel))
    else $error("multicast word count wrong");

    chk_retried_twice:
    assert property ((typ == `PCS1_EVT_UALL && pkt_hit
                      && pkt_unicast_i[dir] && !wr_ctrl && !wr_count)[*2]
                     ##1 !wr_count
                     |=> count == $past(count, 2) + 32'h0000_0002)
    else $error("repeated packet not counted each time");

    chk_reserved_zero:
    assert property (pready_o && psel_i && !pwrite_i
                     && paddr_i == `PCS1_OFF_CTRL
                     |-> (prdata_o & ~`PCS1_CTRL_WMASK) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

    chk_ctrl_hold:
    assert property (!wr_ctrl |=> $stable(ctrl_ff))
    else $error("control changed without a write");

    chk_apb_ready:
    assert property (access && !pready_o |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after access");

    chk_slverr_unmapped:
    assert property (access && !pready_o && !addr_ok
                     |=> pready_o && pslverr_o)
    else $error("unmapped address not refused");

    chk_rdata_idle:
    assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data shown outside a completion");

    chk_status_enable:
    assert property (pready_o && psel_i && !pwrite_i
                     && paddr_i == `PCS1_OFF_STATUS
                     |-> prdata_o[`PCS1_STS_EN_BIT] == $past(enabled_ff))
    else $error("status enable bit wrong");

    chk_count_clear:
    assert property (wr_count |=> count == {25'h0, $past(inc)})
    else $error("count write did not clear");

    chk_count_accum:
    assert property (!wr_count |=> count == $past(count)
                                  + {25'h0, $past(inc)})
    else $error("count did not add the increment");

    chk_enabled_flag:
    assert property (1'b1 |=> ctr1_enabled_o == $past(en))
    else $error("enabled flag does not follow selects");

    cov_word_count:
    cover property (typ == `PCS1_EVT_UWORD && pkt_hit ##2 count != 32'h0);

    cov_retry_sym:
    cover property (typ == `PCS1_EVT_RETRY && sym_hit ##1 inc == 7'h01);

    cov_clear_with_event:
    cover property (wr_count && inc != 7'h00);

    cov_bad_addr:
    cover property (pslverr_o && pready_o);

    cov_tx_direction:
    cover property (dir && pkt_hit ##1 inc != 7'h00);

endmodule

// ===== pcs1_consts.svh
// Offsets, field positions, reset values and codes of the counter-1 select
// Included by the package and by every design file that needs them
`ifndef PCS1_CONSTS_SVH
`define PCS1_CONSTS_SVH

// APB byte offsets
`define PCS1_ADDR_W        12
`define PCS1_OFF_CTRL      12'h000
`define PCS1_OFF_COUNT     12'h004
`define PCS1_OFF_STATUS    12'h008

// Control register field positions
`define PCS1_PRIO3_BIT     16
`define PCS1_PRIO2_BIT     17
`define PCS1_PRIO1_BIT     18
`define PCS1_PRIO0_BIT     19
`define PCS1_DIR_BIT       23
`define PCS1_TYPE_LSB      29
`define PCS1_TYPE_MSB      31
`define PCS1_CTRL_WMASK    32'he08f_0000
`define PCS1_CTRL_RESET    32'h0000_0000

// Status register field positions
`define PCS1_STS_EN_BIT    0
`define PCS1_STS_WRAP_BIT  1

// Event type codes
`define PCS1_EVT_UREQ      3'h0
`define PCS1_EVT_UALL      3'h1
`define PCS1_EVT_RETRY     3'h2
`define PCS1_EVT_CSYM      3'h3
`define PCS1_EVT_UWORD     3'h4
`define PCS1_EVT_MPKT      3'h5
`define PCS1_EVT_MSYM      3'h6
`define PCS1_EVT_MWORD     3'h7

// Widest word count per packet event
`define PCS1_WORD_W        7

`endif

// ===== pcs1_pkg.sv
// Types shared by the counter-1 select block
// Assumes pcs1_consts.svh is on the include path
`include "pcs1_consts.svh"

package pcs1_pkg;

    typedef enum logic [2:0] {
        evt_ureq  = `PCS1_EVT_UREQ,
        evt_uall  = `PCS1_EVT_UALL,
        evt_retry = `PCS1_EVT_RETRY,
        evt_csym  = `PCS1_EVT_CSYM,
        evt_uword = `PCS1_EVT_UWORD,
        evt_mpkt  = `PCS1_EVT_MPKT,
        evt_msym  = `PCS1_EVT_MSYM,
        evt_mword = `PCS1_EVT_MWORD
    } pcs1_evtype_type;

endpackage

// ===== pcs1_event_qual.sv
// Picks one direction, filters by priority and type, registers the increment
// Assumes event inputs come from logic on clk_i
`timescale 1ns/1ps
`include "pcs1_consts.svh"

module pcs1_event_qual (
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic [3:0]                    prio_sel_i,
    input  wire logic                          dir_i,
    input  wire pcs1_pkg::pcs1_evtype_type     type_i,
    input  wire logic [1:0]                    pkt_valid_i,
    input  wire logic [1:0][1:0]               pkt_prio_i,
    input  wire logic [1:0]                    pkt_unicast_i,
    input  wire logic [1:0]                    pkt_multicast_i,
    input  wire logic [1:0]                    pkt_request_i,
    input  wire logic [1:0][`PCS1_WORD_W-1:0]  pkt_words_i,
    input  wire logic [1:0]                    sym_valid_i,
    input  wire logic [1:0]                    sym_retry_i,
    input  wire logic [1:0]                    sym_multicast_i,
    output logic      [`PCS1_WORD_W-1:0]       inc_o
);

    logic [`PCS1_WORD_W-1:0] inc_ff;
    logic [`PCS1_WORD_W-1:0] nxt_inc;
    logic                    pkt;
    logic                    sym;

    always_comb begin
        pkt = pkt_valid_i[dir_i] && prio_sel_i[pkt_prio_i[dir_i]];
        sym = sym_valid_i[dir_i];
        nxt_inc = 7'h00;
        if (|prio_sel_i) begin
            // No retry filter on packet types: each sighting counts
            unique case (type_i)
                pcs1_pkg::evt_ureq:
                    nxt_inc = {6'h00, pkt && pkt_unicast_i[dir_i]
                               && pkt_request_i[dir_i]};
                pcs1_pkg::evt_uall:
                    nxt_inc = {6'h00, pkt && pkt_unicast_i[dir_i]};
                pcs1_pkg::evt_retry:
                    nxt_inc = {6'h00, sym && sym_retry_i[dir_i]};
                pcs1_pkg::evt_csym:
                    nxt_inc = {6'h00, sym && !sym_retry_i[dir_i]};
                pcs1_pkg::evt_uword:
                    nxt_inc = (pkt && pkt_unicast_i[dir_i]) ?
                              pkt_words_i[dir_i] : 7'h00;
                pcs1_pkg::evt_mpkt:
                    nxt_inc = {6'h00, pkt && pkt_multicast_i[dir_i]};
                pcs1_pkg::evt_msym:
                    nxt_inc = {6'h00, sym && sym_multicast_i[dir_i]};
                pcs1_pkg::evt_mword:
                    nxt_inc = (pkt && pkt_multicast_i[dir_i]) ?
                              pkt_words_i[dir_i] : 7'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inc_ff <= 7'h00;
        end else begin
            inc_ff <= nxt_inc;
        end
    end

    assign inc_o = inc_ff;

endmodule

// ===== pcs1_counter.sv
// 32-bit event accumulator with software clear and wrap pulse
// Assumes increment and clear come from logic on clk_i
`timescale 1ns/1ps
`include "pcs1_consts.svh"

module pcs1_counter (
    input  wire logic                    clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    clr_i,
    input  wire logic [`PCS1_WORD_W-1:0] inc_i,
    output logic      [31:0]             count_o,
    output logic                         wrap_o
);

    logic [31:0] count_ff;
    logic        wrap_ff;
    logic [32:0] nxt_sum;

    assign nxt_sum = {1'b0, count_ff} + {26'h0000000, inc_i};

    // An event landing with the clear is kept, not lost
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_ff <= 32'h0000_0000;
            wrap_ff  <= 1'b0;
        end else if (clr_i) begin
            count_ff <= {25'h0000000, inc_i};
            wrap_ff  <= 1'b0;
        end else begin
            count_ff <= nxt_sum[31:0];
            wrap_ff  <= nxt_sum[32];
        end
    end

    assign count_o = count_ff;
    assign wrap_o  = wrap_ff;

endmodule

// ===== pcs1_top_tb.sv
// Self-checking bench for the counter-1 select block
// Assumes pcs1_consts.svh on the include path; bench drives all ports itself
`timescale 1ns/1ps
`include "pcs1_consts.svh"

module pcs1_top_tb;

    typedef struct packed {
        logic       pkt;
        logic       sym;
        logic       dir;
        logic [1:0] prio;
        logic       uni;
        logic       mc;
        logic       req;
        logic       retry;
        logic [6:0] words;
    } pcs1_ev_type;

    logic                         clk_i;
    logic                         rstn_i;
    logic                         psel_i;
    logic                         penable_i;
    logic                         pwrite_i;
    logic [`PCS1_ADDR_W-1:0]      paddr_i;
    logic [31:0]                  pwdata_i;
    logic [3:0]                   pstrb_i;
    logic [31:0]                  prdata_o;
    logic                         pready_o;
    logic                         pslverr_o;
    logic [1:0]                   pkt_valid_i;
    logic [1:0][1:0]              pkt_prio_i;
    logic [1:0]                   pkt_unicast_i;
    logic [1:0]                   pkt_multicast_i;
    logic [1:0]                   pkt_request_i;
    logic [1:0][`PCS1_WORD_W-1:0] pkt_words_i;
    logic [1:0]                   sym_valid_i;
    logic [1:0]                   sym_retry_i;
    logic [1:0]                   sym_multicast_i;
    logic [31:0]                  ctr1_count_o;
    logic                         ctr1_enabled_o;
    int                           mismatches;
    int                           num_checks;

    pcs1_top u_pcs1_top (
        .clk_i           (clk_i),
        .rstn_i          (rstn_i),
        .psel_i          (psel_i),
        .penable_i       (penable_i),
        .pwrite_i        (pwrite_i),
        .paddr_i         (paddr_i),
        .pwdata_i        (pwdata_i),
        .pstrb_i         (pstrb_i),
        .prdata_o        (prdata_o),
        .pready_o        (pready_o),
        .pslverr_o       (pslverr_o),
        .pkt_valid_i     (pkt_valid_i),
        .pkt_prio_i      (pkt_prio_i),
        .pkt_unicast_i   (pkt_unicast_i),
        .pkt_multicast_i (pkt_multicast_i),
        .pkt_request_i   (pkt_request_i),
        .pkt_words_i     (pkt_words_i),
        .sym_valid_i     (sym_valid_i),
        .sym_retry_i     (sym_retry_i),
        .sym_multicast_i (sym_multicast_i),
        .ctr1_count_o    (ctr1_count_o),
        .ctr1_enabled_o  (ctr1_enabled_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; ready, read data and error are taken at one edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready_o", 32'h1, 32'h0);
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic experr, input string name);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(name, exp, r);
        chk("pslverr_o", {31'h0, experr}, {31'h0, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // Fixed traffic mix: a retried request, response, multicast, symbols
    function automatic pcs1_ev_type ev(input int i);
        pcs1_ev_type e;
        e = '0;
        case (i)
            0, 1: begin e.pkt = 1; e.uni = 1; e.req = 1; e.words = 7'h05; end
            2: begin e.pkt = 1; e.uni = 1; e.words = 7'h03; end
            3: begin e.pkt = 1; e.mc = 1; e.words = 7'h04; end
            4: begin e.sym = 1; e.retry = 1; end
            5: e.sym = 1;
            6: begin e.sym = 1; e.mc = 1; end
            7: begin e.pkt = 1; e.uni = 1; e.req = 1; e.prio = 2;
                     e.words = 7'h06; end
            default: begin e.pkt = 1; e.dir = 1; e.uni = 1; e.req = 1;
                     e.words = 7'h07; end
        endcase
        return e;
    endfunction

    task automatic run_events();
        pcs1_ev_type     e;
        logic [1:0]      pv, pu, pm, pr, sv, sr, sm;
        logic [1:0][1:0] pp;
        logic [1:0][6:0] pw;
        for (int i = 0; i < 9; i++) begin
            e = ev(i);
            {pv, pu, pm, pr, sv, sr, sm} = '0;
            pp = '0;
            pw = '0;
            pv[e.dir] = e.pkt;
            pu[e.dir] = e.uni;
            pm[e.dir] = e.pkt & e.mc;
            pr[e.dir] = e.req;
            pp[e.dir] = e.prio;
            pw[e.dir] = e.words;
            sv[e.dir] = e.sym;
            sr[e.dir] = e.retry;
            sm[e.dir] = e.sym & e.mc;
            @(posedge clk_i);
            pkt_valid_i     <= pv;
            pkt_unicast_i   <= pu;
            pkt_multicast_i <= pm;
            pkt_request_i   <= pr;
            pkt_prio_i      <= pp;
            pkt_words_i     <= pw;
            sym_valid_i     <= sv;
            sym_retry_i     <= sr;
            sym_multicast_i <= sm;
        end
        @(posedge clk_i);
        pkt_valid_i <= 2'b00;
        sym_valid_i <= 2'b00;
        repeat (3) @(posedge clk_i);
    endtask

    function automatic logic [31:0] mk(input logic [2:0] t,
                                       input logic [3:0] p, input logic d);
        return {t, 5'h00, d, 3'h0, p, 16'h0000};
    endfunction

    task automatic count_case(input logic [31:0] ctrl, input int exp);
        wr(`PCS1_OFF_CTRL, ctrl);
        wr(`PCS1_OFF_COUNT, 32'h0000_0000);
        run_events();
        chk("ctr1_count_o", exp, ctr1_count_o);
        rd(`PCS1_OFF_COUNT, exp, 1'b0, "count_reg");
        rd(`PCS1_OFF_STATUS, {31'h0, |ctrl[19:16]}, 1'b0, "status_reg");
        chk("ctr1_enabled_o", {31'h0, |ctrl[19:16]}, {31'h0, ctr1_enabled_o});
    endtask

    task automatic test_reset_regs();
        rd(`PCS1_OFF_CTRL, 32'h0000_0000, 1'b0, "ctrl_reset");
        rd(`PCS1_OFF_COUNT, 32'h0000_0000, 1'b0, "count_reset");
        chk("ctr1_enabled_o", 32'h0, {31'h0, ctr1_enabled_o});
    endtask

    task automatic test_reserved();
        wr(`PCS1_OFF_CTRL, 32'hffff_ffff);
        rd(`PCS1_OFF_CTRL, 32'he08f_0000, 1'b0, "ctrl_mask");
        wr(`PCS1_OFF_CTRL, 32'h0000_0000);
        rd(`PCS1_OFF_CTRL, 32'h0000_0000, 1'b0, "ctrl_zero");
    endtask

    task automatic test_unmapped();
        wr(12'h00c, 32'hffff_ffff);
        rd(12'h00c, 32'h0000_0000, 1'b1, "unmapped");
        rd(`PCS1_OFF_CTRL, 32'h0000_0000, 1'b0, "ctrl_kept");
    endtask

    task automatic test_types();
        int exp [8];
        exp = '{2, 3, 1, 2, 13, 1, 1, 4};
        for (int t = 0; t < 8; t++)
            count_case(mk(t[2:0], 4'h8, 1'b0), exp[t]);
    endtask

    task automatic test_dir_prio();
        count_case(mk(3'h1, 4'h8, 1'b1), 1);
        count_case(mk(3'h0, 4'h2, 1'b0), 1);
        count_case(mk(3'h0, 4'ha, 1'b0), 3);
        count_case(mk(3'h2, 4'h1, 1'b0), 1);
        count_case(mk(3'h1, 4'h4, 1'b0), 0);
        count_case(mk(3'h1, 4'h0, 1'b0), 0);
        count_case(mk(3'h4, 4'h0, 1'b1), 0);
    endtask

    initial begin
        rstn_i          = 1'b0;
        psel_i          = 1'b0;
        penable_i       = 1'b0;
        pwrite_i        = 1'b0;
        paddr_i         = '0;
        pwdata_i        = '0;
        pstrb_i         = 4'hf;
        pkt_valid_i     = '0;
        pkt_prio_i      = '0;
        pkt_unicast_i   = '0;
        pkt_multicast_i = '0;
        pkt_request_i   = '0;
        pkt_words_i     = '0;
        sym_valid_i     = '0;
        sym_retry_i     = '0;
        sym_multicast_i = '0;
        mismatches      = 0;
        num_checks      = 0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        test_reset_regs();
        test_reserved();
        test_unmapped();
        test_types();
        test_dir_prio();
        end_of_test();
    end

    // Whole run needs a few hundred cycles; this cuts a hang short
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end

endmodule
